// File: prm_board_model.sv
/*
  Board-side pin model for the register macrocell array.
  Assumes io_oe_n low means the array drives the pin.
*/
`timescale 1ns/1ns
module prm_board_model
  import prm_pkg::*;
(
  input wire logic [PRM_CELLS-1:0] io_out,
  input wire logic [PRM_CELLS-1:0] io_oe_n,
  input wire logic [PRM_CELLS-1:0] ext,
  output logic [PRM_CELLS-1:0] io_in
);
  // Driving cell wins, else the board level shows
  assign io_in = (io_out & ~io_oe_n) | (ext & io_oe_n);
endmodule

// File: prm_macrocell_array.sv
/*
  Register macrocell array: twenty configurable flip-flops, two per
  output cell, with pin and feedback paths and AHB-Lite configuration.
  Assumes all array and pin inputs are synchronous to hclk; clock
  terms and the clock pin are sampled and edge-detected on hclk.
*/
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
module prm_macrocell_array
  import prm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire prm_terms_s terms,
  input wire logic pin_clk,
  input wire logic sync_preset,
  input wire logic [PRM_CELLS-1:0] io_in,
  output logic [PRM_CELLS-1:0] io_out,
  output logic [PRM_CELLS-1:0] io_oe_n,
  output logic [PRM_REGS-1:0] fb_out,
  output logic [PRM_CELLS-1:0] pin_fb
);

  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  logic legacy;
  logic secure;
  logic [PRM_REGS-1:0] ttype;
  logic [PRM_REGS-1:0] clksel;
  logic [PRM_CELLS-1:0] outsel;
  logic [PRM_CELLS-1:0] pol;
  logic [31:0] user_signature_row;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic wr_pend;
  logic [3:0] wr_idx;
  logic [31:0] next_rdata;

  wire addr_ok = hsel && hready && (htrans == PRM_HTRANS_NONSEQ);
  wire [3:0] a_idx = haddr[5:2];
  wire do_write = wr_pend;
  wire cfg_read = (a_idx <= PRM_IDX_SIG);

  function automatic logic [31:0] cfg_word(input logic [3:0] idx,
    input logic [31:0] sig, input logic lg, input logic sc,
    input logic [PRM_REGS-1:0] tt, input logic [PRM_REGS-1:0] cs,
    input logic [PRM_CELLS-1:0] os, input logic [PRM_CELLS-1:0] pl);
    logic [31:0] w;
    w = PRM_RST_WORD;
    if (idx == PRM_IDX_CTRL)
      w[PRM_CTRL_SECURE:PRM_CTRL_LEGACY] = {sc, lg};
    else if (idx == PRM_IDX_TTYPE)
      w[PRM_REGS-1:0] = tt;
    else if (idx == PRM_IDX_CLKSEL)
      w[PRM_REGS-1:0] = cs;
    else if (idx == PRM_IDX_OUTSEL)
      w[PRM_CELLS-1:0] = os;
    else if (idx == PRM_IDX_POL)
      w[PRM_CELLS-1:0] = pl;
    else if (idx == PRM_IDX_SIG)
      w = sig;
    return w;
  endfunction

  // ----------------------------------------
  // Register cells
  // ----------------------------------------
  logic [PRM_REGS-1:0] state;
  logic [PRM_REGS-1:0] src_prev;
  logic [PRM_REGS-1:0] ckt_prev;

  // Legacy mode overrides the stored choices without losing them
  wire [PRM_REGS-1:0] t_eff = legacy ? '0 : ttype;
  wire [PRM_REGS-1:0] pin_eff = legacy ? '0 : clksel;
  wire [PRM_CELLS-1:0] osel_eff = legacy ? '0 : outsel;
  wire [PRM_REGS-1:0] src =
    (pin_eff & {PRM_REGS{pin_clk}}) | (~pin_eff & terms.ckt);
  wire [PRM_REGS-1:0] ev = src & ~src_prev;
  wire [PRM_REGS-1:0] ckt_rise = terms.ckt & ~ckt_prev;
  // Preset only acts on a clock event, so the array must raise clocks
  wire [PRM_REGS-1:0] d_next = sync_preset ? '1 :
    ((t_eff & (state ^ terms.sum)) | (~t_eff & terms.sum));
  // Reset term wins over preset and data in the same cycle
  wire [PRM_REGS-1:0] next_state =
    ~terms.arst & ((ev & d_next) | (~ev & state));

  // Cell k: register 2k is the main output, 2k+1 the buried one
  logic [PRM_CELLS-1:0] cell_q;
  always_comb
  begin
    for (int k = 0; k < PRM_CELLS; k++)
      cell_q[k] = osel_eff[k] ? state[2*k+1] : state[2*k];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= '0;
      src_prev <= '0;
      ckt_prev <= '0;
    end
    else
    begin
      state <= next_state;
      src_prev <= src;
      ckt_prev <= terms.ckt;
    end
  end

  // ----------------------------------------
  // Pins and feedback
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      io_out <= '0;
      io_oe_n <= '1;
      pin_fb <= '0;
    end
    else
    begin
      io_out <= cell_q ^ pol;
      io_oe_n <= ~terms.oe;
      pin_fb <= io_in;
    end
  end

  assign fb_out = state;

  // ----------------------------------------
  // Register file and bus answer
  // ----------------------------------------
  // Once secured, every configuration read shows all ones
  assign next_rdata = (a_idx == PRM_IDX_STATE) ? {12'h000, state} :
    (a_idx == PRM_IDX_PINS) ? {22'h000000, pin_fb} :
    !cfg_read ? PRM_RST_WORD :
    secure ? PRM_MASKED_WORD :
    cfg_word(a_idx, user_signature_row, legacy, secure, ttype, clksel,
      outsel, pol);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_idx <= 4'h0;
      hrdata <= PRM_RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      wr_idx <= a_idx;
      if (addr_ok && !hwrite)
        hrdata <= next_rdata;
    end
  end

  // Security is sticky; only a full reset clears it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      legacy <= 1'b0;
      secure <= 1'b0;
      ttype <= '0;
      clksel <= '0;
      outsel <= '0;
      pol <= '0;
      user_signature_row <= PRM_RST_WORD;
    end
    else if (do_write)
    begin
      if (wr_idx == PRM_IDX_CTRL)
      begin
        legacy <= hwdata[PRM_CTRL_LEGACY];
        secure <= secure | hwdata[PRM_CTRL_SECURE];
      end
      else if (wr_idx == PRM_IDX_TTYPE)
        ttype <= hwdata[PRM_REGS-1:0];
      else if (wr_idx == PRM_IDX_CLKSEL)
        clksel <= hwdata[PRM_REGS-1:0];
      else if (wr_idx == PRM_IDX_OUTSEL)
        outsel <= hwdata[PRM_CELLS-1:0];
      else if (wr_idx == PRM_IDX_POL)
        pol <= hwdata[PRM_CELLS-1:0];
      else if (wr_idx == PRM_IDX_SIG)
        user_signature_row <= hwdata;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_arst_clears: assert property (
    1'b1 |=> (state & $past(terms.arst)) == '0)
    else $error("reset term did not clear register");
  a_preset_sets: assert property (
    sync_preset |=> ((state | $past(terms.arst) | ~$past(ev)) == '1))
    else $error("preset did not set clocked registers");
  a_hold_no_event: assert property (
    1'b1 |=> ((state ^ $past(state)) & ~$past(ev) &
      ~$past(terms.arst)) == '0)
    else $error("register changed without clock event");
  a_d_load: assert property (
    !sync_preset |=> ((state ^ $past(terms.sum)) & $past(ev) &
      ~$past(terms.arst) & ~$past(t_eff)) == '0)
    else $error("D register did not load sum term");
  a_t_toggle: assert property (
    !sync_preset |=> ((state ^ $past(state) ^ $past(terms.sum)) &
      $past(ev) & ~$past(terms.arst) & $past(t_eff)) == '0)
    else $error("T register toggle wrong");
  a_legacy_term_clk: assert property (
    legacy |-> (ev & ~ckt_rise) == '0)
    else $error("legacy mode used pin clock");
  a_oe_follow: assert property (
    1'b1 |=> io_oe_n == ~$past(terms.oe))
    else $error("output enable not per term");
  a_pin_path: assert property (
    1'b1 |=> pin_fb == $past(io_in))
    else $error("pin input path wrong");
  a_secure_mask: assert property (
    secure && addr_ok && !hwrite && cfg_read |=>
      hrdata == PRM_MASKED_WORD)
    else $error("secured configuration read not masked");

  // ----------------------------------------
  // Bus, configuration, pin output and register clocking checks
  // ----------------------------------------
  // Reads are judged one cycle on, when hrdata has been loaded
  a_secure_sticky: assert property (
    secure |=> secure)
    else $error("security bit cleared without reset");
  a_pol_output: assert property (
    1'b1 |=> io_out == ($past(cell_q) ^ $past(pol)))
    else $error("pin output ignores polarity");
  a_legacy_d_type: assert property (
    legacy && !sync_preset |=> ((state ^ $past(terms.sum)) & $past(ev) &
      ~$past(terms.arst)) == '0)
    else $error("legacy register did not load as D type");
  a_ttype_write: assert property (
    do_write && wr_idx == PRM_IDX_TTYPE |=>
      ttype == $past(hwdata[PRM_REGS-1:0]))
    else $error("type selection write lost");
  a_clksel_write: assert property (
    do_write && wr_idx == PRM_IDX_CLKSEL |=>
      clksel == $past(hwdata[PRM_REGS-1:0]))
    else $error("clock selection write lost");
  a_outsel_write: assert property (
    do_write && wr_idx == PRM_IDX_OUTSEL |=>
      outsel == $past(hwdata[PRM_CELLS-1:0]))
    else $error("output selection write lost");
  a_state_read: assert property (
    addr_ok && !hwrite && a_idx == PRM_IDX_STATE |=>
      hrdata[PRM_REGS-1:0] == $past(state))
    else $error("state read does not show feedback");
  a_pins_read: assert property (
    addr_ok && !hwrite && a_idx == PRM_IDX_PINS |=>
      hrdata[PRM_CELLS-1:0] == $past(pin_fb))
    else $error("pin read does not show input path");
  a_private_clock: assert property (
    1'b1 |=> ((state ^ $past(state)) & ~$past(pin_eff) &
      ~$past(ckt_rise) & ~$past(terms.arst)) == '0)
    else $error("term-clocked register moved without its own term");

endmodule

// File: prm_macrocell_array_tb.sv
/*
  Self-checking bench for the register macrocell array.
  Assumes one AHB-Lite slave and the board pin model on the pins.
*/
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module prm_macrocell_array_tb import prm_pkg::*;;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic pin_clk = 1'h0;
  logic sync_preset = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic hready;
  logic hresp;
  prm_terms_s terms = '0;
  logic [9:0] ext = 10'h0;
  logic [9:0] io_in;
  logic [9:0] io_out;
  logic [9:0] io_oe_n;
  logic [9:0] pin_fb;
  logic [19:0] fb_out;
  int num_errors = 0;
  int compares = 0;

  always #20 hclk = ~hclk;

  prm_macrocell_array i_prm_macrocell_array (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .terms(terms),
    .pin_clk(pin_clk), .sync_preset(sync_preset), .io_in(io_in),
    .io_out(io_out), .io_oe_n(io_oe_n), .fb_out(fb_out),
    .pin_fb(pin_fb));

  prm_board_model i_prm_board_model (.io_out(io_out),
    .io_oe_n(io_oe_n), .ext(ext), .io_in(io_in));

  task results;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Bounded wait, a stuck hready ends the run
  task rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1)
    begin
      num_errors++;
      results;
    end
  endtask

  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= PRM_HTRANS_NONSEQ;
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdc(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Source low before and after, so each pulse is one event
  task ev(input logic [19:0] m, input logic p);
    @(posedge hclk);
    terms.ckt <= m;
    pin_clk <= p;
    @(posedge hclk);
    terms.ckt <= 20'h0;
    pin_clk <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  initial
  begin
    repeat (2) @(posedge hclk);
    `CHK(io_oe_n, 10'h3FF)
    `CHK(io_out, 10'h0)
    `CHK(fb_out, 20'h0)
    `CHK(hresp, 1'b0)
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 9; i++)
      rdc(32'(4 * i), 32'h0);
    wr(32'h04, 32'h2);
    wr(32'h08, 32'h4);
    rdc(32'h04, 32'h2);
    terms.sum <= 20'h00007;
    ev(20'h00007, 1'b0);
    rdc(32'h18, 32'h3);
    ev(20'h00007, 1'b0);
    rdc(32'h18, 32'h1);
    ev(20'h00000, 1'b1);
    rdc(32'h18, 32'h5);
    `CHK(fb_out, 20'h00005)
    sync_preset <= 1'b1;
    terms.arst <= 20'h00008;
    ev(20'hFFFFF, 1'b1);
    rdc(32'h18, 32'hFFFF7);
    sync_preset <= 1'b0;
    terms.arst <= 20'h00001;
    repeat (2) @(posedge hclk);
    rdc(32'h18, 32'hFFFF6);
    terms.arst <= 20'h0;
    terms.oe <= 10'h001;
    ext <= 10'h2A0;
    wr(32'h10, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK(io_oe_n, 10'h3FE)
    `CHK(io_out, 10'h3FF)
    rdc(32'h1C, 32'h2A1);
    wr(32'h0C, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK(io_out, 10'h3FE)
    wr(32'h00, 32'h1);
    terms.sum <= 20'h0;
    ev(20'hFFFFF, 1'b0);
    rdc(32'h18, 32'h0);
    wr(32'h14, 32'h5A3C_96E1);
    rdc(32'h14, 32'h5A3C_96E1);
    wr(32'h00, 32'h2);
    rdc(32'h04, 32'hFFFFFFFF);
    rdc(32'h14, 32'hFFFFFFFF);
    wr(32'h00, 32'h0);
    rdc(32'h00, 32'hFFFFFFFF);
    rdc(32'h18, 32'h0);
    terms.sum <= 20'hFFFFF;
    ev(20'hFFFFF, 1'b1);
    rdc(32'h18, 32'hFFFFF);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK(fb_out, 20'h0)
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(32'h00, 32'h0);
    rdc(32'h18, 32'h0);
    results;
  end
endmodule

// File: prm_pkg.sv
/*
  Package for the register macrocell array: sizes, register map,
  reset values and the packed carrier for product-term inputs.
  Assumes a single 25 MHz clock and an AHB-Lite register bus.
*/
package prm_pkg;

  // ----------------------------------------
  // Array sizes
  // ----------------------------------------
  localparam int PRM_CELLS = 10;
  localparam int PRM_REGS = 2 * PRM_CELLS;

  // ----------------------------------------
  // Register map (byte addresses, word index in haddr[5:2])
  // ----------------------------------------
  localparam logic [3:0] PRM_IDX_CTRL = 4'h0;
  localparam logic [3:0] PRM_IDX_TTYPE = 4'h1;
  localparam logic [3:0] PRM_IDX_CLKSEL = 4'h2;
  localparam logic [3:0] PRM_IDX_OUTSEL = 4'h3;
  localparam logic [3:0] PRM_IDX_POL = 4'h4;
  localparam logic [3:0] PRM_IDX_SIG = 4'h5;
  localparam logic [3:0] PRM_IDX_STATE = 4'h6;
  localparam logic [3:0] PRM_IDX_PINS = 4'h7;

  // ----------------------------------------
  // Control field positions and reset values
  // ----------------------------------------
  localparam int PRM_CTRL_LEGACY = 0;
  localparam int PRM_CTRL_SECURE = 1;
  localparam logic [31:0] PRM_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] PRM_MASKED_WORD = 32'hFFFF_FFFF;
  localparam logic [1:0] PRM_HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------
  // Product-term carrier
  // ----------------------------------------
  typedef struct packed {
    logic [PRM_REGS-1:0] sum;
    logic [PRM_REGS-1:0] arst;
    logic [PRM_REGS-1:0] ckt;
    logic [PRM_CELLS-1:0] oe;
  } prm_terms_s;

endpackage
